/* core/phy_mgmt_access.sv */
// phy management access register and management frame engine
//
// Overview of operation
// - low five bits of the access register pick the phy register index.
// - bits 12:8 give the phy device address used in the frame.
// - command bit clear makes the frame a read of the chosen register.
// - read completion puts the sixteen returned bits into bits 31:16.
// - command bit set writes the data field to the chosen register.
// - writing the access register sets the busy bit at once.
// - busy bit clears only after the whole frame has finished.
// - this register is the only software path to phy registers.
`default_nettype none
module phy_mgmt_access (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic [phy_mgmt_pkg::ADDR_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic irq_o,
	output logic mdc_o,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_n_o
);
	phy_mgmt_pkg::mgmt_state_e state;
	phy_mgmt_pkg::mgmt_state_e next_state;
	logic [4:0] phy_reg_index;
	logic [4:0] next_phy_reg_index;
	logic [4:0] phy_device_addr;
	logic [4:0] next_phy_device_addr;
	logic phy_cmd_write;
	logic next_phy_cmd_write;
	logic phy_cmd_busy;
	logic next_phy_cmd_busy;
	logic [15:0] phy_xfer_data;
	logic [15:0] next_phy_xfer_data;
	logic [phy_mgmt_pkg::FRAME_W-1:0] shreg;
	logic [phy_mgmt_pkg::FRAME_W-1:0] next_shreg;
	logic [5:0] bit_cnt;
	logic [5:0] next_bit_cnt;
	logic next_mdc;
	logic next_mdio;
	logic next_mdio_oe_n;
	logic irq_status;
	logic next_irq_status;
	logic irq_mask;
	logic next_irq_mask;
	logic [31:0] next_rdata;
	logic mdio_s;
	logic tick;
	logic launch;
	logic done_evt;
	logic [31:0] access_view;

	bit_sync u_mdio_sync (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.din_i(mdio_i),
		.dout_o(mdio_s)
	);

	half_period_tick u_tick (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.en_i(state != phy_mgmt_pkg::ST_IDLE),
		.tick_o(tick)
	);

	// writes during a transaction are refused so the frame in flight stays intact
	assign launch = wr_i && (addr_i == phy_mgmt_pkg::OFS_ACCESS) && !phy_cmd_busy;
	assign done_evt = (state == phy_mgmt_pkg::ST_END) && tick;

	assign access_view = {phy_xfer_data, phy_cmd_busy, 2'h0, phy_device_addr,
		phy_cmd_write, 2'h0, phy_reg_index};

	// register file and command launch
	always_comb begin
		next_phy_reg_index = phy_reg_index;
		next_phy_device_addr = phy_device_addr;
		next_phy_cmd_write = phy_cmd_write;
		next_irq_mask = irq_mask;
		next_rdata = 32'h00000000;
		if (launch) begin
			next_phy_reg_index = wdata_i[phy_mgmt_pkg::REG_IDX_MSB:phy_mgmt_pkg::REG_IDX_LSB];
			next_phy_device_addr = wdata_i[phy_mgmt_pkg::PHY_ADDR_MSB:phy_mgmt_pkg::PHY_ADDR_LSB];
			next_phy_cmd_write = wdata_i[phy_mgmt_pkg::CMD_WRITE_BIT];
		end
		if (wr_i && addr_i == phy_mgmt_pkg::OFS_IRQ_MASK) begin
			next_irq_mask = wdata_i[phy_mgmt_pkg::IRQ_DONE_BIT];
		end
		if (rd_i) begin
			case (addr_i)
				phy_mgmt_pkg::OFS_ACCESS: begin
					next_rdata = access_view;
				end
				phy_mgmt_pkg::OFS_IRQ_STATUS: begin
					next_rdata = {31'h00000000, irq_status};
				end
				phy_mgmt_pkg::OFS_IRQ_MASK: begin
					next_rdata = {31'h00000000, irq_mask};
				end
				default: begin
					next_rdata = 32'h00000000;
				end
			endcase
		end
	end

	// done event is sticky; a new event beats a simultaneous write-one clear
	always_comb begin
		next_irq_status = irq_status;
		if (wr_i && addr_i == phy_mgmt_pkg::OFS_IRQ_STATUS && wdata_i[phy_mgmt_pkg::IRQ_DONE_BIT]) begin
			next_irq_status = 1'b0;
		end
		if (done_evt) begin
			next_irq_status = 1'b1;
		end
	end

	// frame engine: bits change after mdc falls and are sampled as mdc rises
	always_comb begin
		next_state = state;
		next_phy_cmd_busy = phy_cmd_busy;
		next_phy_xfer_data = phy_xfer_data;
		next_shreg = shreg;
		next_bit_cnt = bit_cnt;
		next_mdc = mdc_o;
		next_mdio = mdio_o;
		next_mdio_oe_n = mdio_oe_n_o;
		case (state)
			phy_mgmt_pkg::ST_IDLE: begin
				next_mdc = 1'b0;
				next_mdio_oe_n = 1'b1;
				next_mdio = 1'b1;
				if (launch) begin
					next_phy_cmd_busy = 1'b1;
					next_state = phy_mgmt_pkg::ST_RUN;
					next_bit_cnt = 6'h00;
					if (wdata_i[phy_mgmt_pkg::CMD_WRITE_BIT]) begin
						next_phy_xfer_data = wdata_i[phy_mgmt_pkg::DATA_MSB:phy_mgmt_pkg::DATA_LSB];
						next_shreg = {phy_mgmt_pkg::PREAMBLE, phy_mgmt_pkg::START_CODE, phy_mgmt_pkg::OP_WRITE,
							wdata_i[phy_mgmt_pkg::PHY_ADDR_MSB:phy_mgmt_pkg::PHY_ADDR_LSB],
							wdata_i[phy_mgmt_pkg::REG_IDX_MSB:phy_mgmt_pkg::REG_IDX_LSB],
							phy_mgmt_pkg::TA_WRITE,
							wdata_i[phy_mgmt_pkg::DATA_MSB:phy_mgmt_pkg::DATA_LSB]};
					end else begin
						next_shreg = {phy_mgmt_pkg::PREAMBLE, phy_mgmt_pkg::START_CODE, phy_mgmt_pkg::OP_READ,
							wdata_i[phy_mgmt_pkg::PHY_ADDR_MSB:phy_mgmt_pkg::PHY_ADDR_LSB],
							wdata_i[phy_mgmt_pkg::REG_IDX_MSB:phy_mgmt_pkg::REG_IDX_LSB],
							phy_mgmt_pkg::TA_WRITE, phy_mgmt_pkg::DATA_RST};
					end
					next_mdio = 1'b1;
					next_mdio_oe_n = 1'b0;
				end
			end
			phy_mgmt_pkg::ST_RUN: begin
				if (tick) begin
					next_mdc = !mdc_o;
					if (!mdc_o) begin
						if (!phy_cmd_write && bit_cnt >= phy_mgmt_pkg::POS_DATA) begin
							next_phy_xfer_data = {phy_xfer_data[14:0], mdio_s};
						end
					end else if (bit_cnt == phy_mgmt_pkg::POS_LAST) begin
						next_state = phy_mgmt_pkg::ST_END;
						next_mdio_oe_n = 1'b1;
						next_mdio = 1'b1;
					end else begin
						next_bit_cnt = bit_cnt + 6'h01;
						next_shreg = {shreg[phy_mgmt_pkg::FRAME_W-2:0], 1'b1};
						next_mdio = shreg[phy_mgmt_pkg::FRAME_W-2];
						// read frames hand the line to the phy from the turnaround on
						next_mdio_oe_n = !phy_cmd_write && (bit_cnt + 6'h01 >= phy_mgmt_pkg::POS_TA);
					end
				end
			end
			phy_mgmt_pkg::ST_END: begin
				next_mdc = 1'b0;
				if (tick) begin
					next_phy_cmd_busy = 1'b0;
					next_state = phy_mgmt_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = phy_mgmt_pkg::ST_IDLE;
				next_phy_cmd_busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			phy_reg_index <= phy_mgmt_pkg::REG_IDX_RST;
			phy_device_addr <= phy_mgmt_pkg::PHY_ADDR_RST;
			phy_cmd_write <= 1'b0;
			irq_mask <= phy_mgmt_pkg::IRQ_RST;
			irq_status <= phy_mgmt_pkg::IRQ_RST;
			rdata_o <= 32'h00000000;
		end else begin
			phy_reg_index <= next_phy_reg_index;
			phy_device_addr <= next_phy_device_addr;
			phy_cmd_write <= next_phy_cmd_write;
			irq_mask <= next_irq_mask;
			irq_status <= next_irq_status;
			rdata_o <= next_rdata;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= phy_mgmt_pkg::ST_IDLE;
			phy_cmd_busy <= 1'b0;
			phy_xfer_data <= phy_mgmt_pkg::DATA_RST;
			shreg <= '1;
			bit_cnt <= 6'h00;
			mdc_o <= 1'b0;
			mdio_o <= 1'b1;
			mdio_oe_n_o <= 1'b1;
		end else begin
			state <= next_state;
			phy_cmd_busy <= next_phy_cmd_busy;
			phy_xfer_data <= next_phy_xfer_data;
			shreg <= next_shreg;
			bit_cnt <= next_bit_cnt;
			mdc_o <= next_mdc;
			mdio_o <= next_mdio;
			mdio_oe_n_o <= next_mdio_oe_n;
		end
	end

	assign irq_o = irq_status & irq_mask;

	// checks
	logic run_fall;
	assign run_fall = (state == phy_mgmt_pkg::ST_RUN) && mdc_o;

	sequence launch_s;
		launch;
	endsequence

	sequence frame_end_s;
		(state == phy_mgmt_pkg::ST_END) && tick;
	endsequence

	busy_on_launch_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		launch_s |=> phy_cmd_busy && state == phy_mgmt_pkg::ST_RUN)
		else $error("busy not set after access write");

	busy_held_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		phy_cmd_busy && state != phy_mgmt_pkg::ST_END |=> phy_cmd_busy)
		else $error("busy dropped before frame end");

	busy_clear_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		frame_end_s |=> !phy_cmd_busy && state == phy_mgmt_pkg::ST_IDLE)
		else $error("busy not cleared at frame end");

	start_code_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		run_fall && bit_cnt == phy_mgmt_pkg::POS_START |-> !mdio_o && !mdio_oe_n_o)
		else $error("start code first bit wrong");

	opcode_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		run_fall && bit_cnt == phy_mgmt_pkg::POS_OP |-> mdio_o == !phy_cmd_write)
		else $error("opcode first bit wrong");

	phy_addr_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		run_fall && bit_cnt == phy_mgmt_pkg::POS_PHY |-> mdio_o == phy_device_addr[4])
		else $error("phy address msb wrong");

	reg_index_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		run_fall && bit_cnt == phy_mgmt_pkg::POS_REG |-> mdio_o == phy_reg_index[4])
		else $error("register index msb wrong");

	write_data_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		run_fall && phy_cmd_write && bit_cnt == phy_mgmt_pkg::POS_DATA |-> mdio_o == phy_xfer_data[15])
		else $error("write data msb wrong");

	read_release_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		run_fall && !phy_cmd_write && bit_cnt >= phy_mgmt_pkg::POS_TA |-> mdio_oe_n_o)
		else $error("line driven during read turnaround");

	read_capture_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		state == phy_mgmt_pkg::ST_RUN && tick && !mdc_o && !phy_cmd_write && bit_cnt >= phy_mgmt_pkg::POS_DATA
		|=> phy_xfer_data[0] == $past(mdio_s))
		else $error("read bit not captured");

	done_status_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		frame_end_s |=> irq_status)
		else $error("done status not set at frame end");

	idle_lines_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		state == phy_mgmt_pkg::ST_IDLE |-> mdio_oe_n_o && !mdc_o)
		else $error("line not released while idle");

	// the held data of a write frame is read back as the data field, so it must not move while busy
	busy_refuse_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		wr_i && addr_i == phy_mgmt_pkg::OFS_ACCESS && phy_cmd_busy
		|=> $stable(phy_reg_index) && $stable(phy_device_addr) && $stable(phy_cmd_write)
		&& (!phy_cmd_write || $stable(phy_xfer_data)))
		else $error("access write taken while busy");
endmodule : phy_mgmt_access
`default_nettype wire

/* core/phy_mgmt_pkg.sv */
// constants shared by the phy management access block
`default_nettype none
package phy_mgmt_pkg;
	// register byte offsets on the plain register port
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_ACCESS = 4'h0;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h8;
	// access register fields
	localparam int REG_IDX_LSB = 0;
	localparam int REG_IDX_MSB = 4;
	localparam int CMD_WRITE_BIT = 7;
	localparam int PHY_ADDR_LSB = 8;
	localparam int PHY_ADDR_MSB = 12;
	localparam int BUSY_BIT = 15;
	localparam int DATA_LSB = 16;
	localparam int DATA_MSB = 31;
	localparam logic [4:0] REG_IDX_RST = 5'h00;
	localparam logic [4:0] PHY_ADDR_RST = 5'h00;
	localparam logic [15:0] DATA_RST = 16'h0000;
	// interrupt status and mask layout
	localparam int IRQ_DONE_BIT = 0;
	localparam logic [0:0] IRQ_RST = 1'h0;
	// management clock timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int MDC_HALF_NS = 200;
	localparam int MDC_HALF_CYC = (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIV_W = 4;
	// management frame layout, bit positions counted from the first preamble bit
	localparam int FRAME_W = 64;
	localparam logic [5:0] POS_START = 6'h20;
	localparam logic [5:0] POS_OP = 6'h22;
	localparam logic [5:0] POS_PHY = 6'h24;
	localparam logic [5:0] POS_REG = 6'h29;
	localparam logic [5:0] POS_TA = 6'h2E;
	localparam logic [5:0] POS_DATA = 6'h30;
	localparam logic [5:0] POS_LAST = 6'h3F;
	localparam logic [31:0] PREAMBLE = 32'hFFFFFFFF;
	localparam logic [1:0] START_CODE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] TA_WRITE = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_END = 2'b10
	} mgmt_state_e;
endpackage : phy_mgmt_pkg
`default_nettype wire

/* core/bit_sync.sv */
// two flip-flop synchroniser for one level from outside the clock domain
`default_nettype none
module bit_sync (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic din_i,
	output logic dout_o
);
	logic meta;
	logic next_meta;
	logic next_dout;

	always_comb begin
		next_meta = din_i;
		next_dout = meta;
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta <= 1'b1;
			dout_o <= 1'b1;
		end else begin
			meta <= next_meta;
			dout_o <= next_dout;
		end
	end
endmodule : bit_sync
`default_nettype wire

/* core/half_period_tick.sv */
// enable pulse generator for each half period of the management clock
`default_nettype none
module half_period_tick (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic en_i,
	output logic tick_o
);
	localparam logic [phy_mgmt_pkg::DIV_W-1:0] LAST =
		phy_mgmt_pkg::DIV_W'(phy_mgmt_pkg::MDC_HALF_CYC - 1);
	logic [phy_mgmt_pkg::DIV_W-1:0] cnt;
	logic [phy_mgmt_pkg::DIV_W-1:0] next_cnt;
	logic next_tick;

	// counter restarts when idle so every frame starts with a full half period
	always_comb begin
		next_cnt = '0;
		next_tick = 1'b0;
		if (en_i) begin
			if (cnt == LAST) begin
				next_tick = 1'b1;
			end else begin
				next_cnt = cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick_o <= next_tick;
		end
	end
endmodule : half_period_tick
`default_nettype wire

/* sim/phy_model.sv */
// behavioural phy management slave with a pulled-up data line
`default_nettype none
module phy_model #(
	parameter logic [4:0] PHY_ADDR = 5'h13
) (
	input wire logic mdc_i,
	input wire logic dev_i,
	input wire logic oe_n_i,
	output logic line_o,
	output logic [63:0] frame_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] regs [32];
	logic [63:0] sh = 64'h0;
	logic drv = 1'b0;
	logic val = 1'b0;
	logic rd_sel = 1'b0;
	logic [4:0] ridx = 5'h00;
	int cnt = 0;
	// released line floats high through the pull-up
	assign line_o = !oe_n_i ? dev_i : (drv ? val : 1'b1);
	initial begin
		for (int i = 0; i < 32; i++) begin
			regs[i] = 16'h5A00 | 16'(i);
		end
	end
	always @(negedge oe_n_i) begin
		cnt = 0;
		rd_sel = 1'b0;
		frame_o = 'x;
	end
	always @(posedge mdc_i) begin
		sh = {sh[62:0], line_o};
		cnt++;
		if (cnt == 46) begin
			rd_sel = sh[11:10] == 2'b10 && sh[9:5] == PHY_ADDR;
			ridx = sh[4:0];
		end
		if (cnt == 64) begin
			frame_o = sh;
			if (sh[29:28] == 2'b01 && sh[27:23] == PHY_ADDR) begin
				regs[sh[22:18]] = sh[15:0];
			end
		end
	end
	// answer only once the master has seen the previous rise
	always @(negedge mdc_i) begin
		drv = rd_sel && cnt >= 47 && cnt <= 63;
		val = (cnt == 47) ? 1'b0 : regs[ridx][(63 - cnt) & 15];
	end
endmodule : phy_model
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the phy management access block
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	wire logic [31:0] rdata_o;
	wire logic irq_o;
	wire logic mdc_o;
	wire logic mdio_o;
	wire logic mdio_oe_n_o;
	wire logic mdio_line;
	wire logic [63:0] frame;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [15:0] seed = 16'h4327;
	logic [15:0] shadow [32];
	always #10 clk_sys_i = ~clk_sys_i;
	phy_mgmt_access phy_mgmt_access_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .mdc_o(mdc_o),
		.mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o));
	phy_model phy_model_i (.mdc_i(mdc_o), .dev_i(mdio_o), .oe_n_i(mdio_oe_n_o), .line_o(mdio_line),
		.frame_o(frame));
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task automatic finish_test;
		if (error_cnt == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : finish_test
	// a frame takes about 1300 cycles, eight of them fit well below the ceiling
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			finish_test();
		end
	end
	initial begin
		logic [31:0] v;
		logic [31:0] cmd;
		logic [4:0] pa;
		logic [4:0] ri;
		logic w;
		logic [15:0] d;
		logic [15:0] xd;
		logic [63:0] ef;
		for (int i = 0; i < 32; i++) shadow[i] = 16'h5A00 | 16'(i);
		repeat (16) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			rd(4'(4 * k), v);
			chk("reset value", 32'h0, v);
		end
		chk("idle lines", 3'h3, {mdc_o, mdio_oe_n_o, mdio_o});
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			pa = seed[0] ? 5'h13 : seed[5:1];
			ri = seed[10:6];
			w = seed[11];
			seed = lfsr(seed);
			d = seed;
			// corners: all-ones write to the top index, then read it back
			if (i == 0) {pa, ri, w, d} = {5'h13, 5'h1F, 1'b1, 16'hFFFF};
			if (i == 1) {pa, ri, w} = {5'h13, 5'h1F, 1'b0};
			if (w && ri == 5'h00) ri = 5'h01;
			wr(phy_mgmt_pkg::OFS_IRQ_MASK, {31'h0, i[0]});
			cmd = {d, 3'h0, pa, w, 2'h0, ri};
			wr(phy_mgmt_pkg::OFS_ACCESS, cmd);
			rd(phy_mgmt_pkg::OFS_ACCESS, v);
			chk("busy set", 1'b1, v[15]);
			// deliberate change while busy: must be ignored
			wr(phy_mgmt_pkg::OFS_ACCESS, cmd ^ 32'hFFFF0080);
			for (int n = 0; n < 1500 && v[15] !== 1'b0; n++) rd(phy_mgmt_pkg::OFS_ACCESS, v);
			chk("busy clear", 1'b0, v[15]);
			ef = {32'hFFFFFFFF, 2'h1, w ? 2'h1 : 2'h2, pa, ri, 2'h2, d};
			if (w) begin
				chk("write frame", ef, frame);
				if (pa == 5'h13) shadow[ri] = d;
				xd = d;
			end else begin
				chk("read frame", ef[63:18], frame[63:18]);
				xd = (pa == 5'h13) ? shadow[ri] : 16'hFFFF;
			end
			chk("access fields", {xd, 3'h0, pa, w, 2'h0, ri}, v);
			rd(phy_mgmt_pkg::OFS_IRQ_STATUS, v);
			chk("done status", 32'h1, v);
			chk("irq level", i[0], irq_o);
			wr(phy_mgmt_pkg::OFS_IRQ_STATUS, 32'h1);
			rd(phy_mgmt_pkg::OFS_IRQ_STATUS, v);
			chk("status cleared", 32'h0, v);
			chk("irq cleared", 1'b0, irq_o);
			chk("idle lines", 3'h3, {mdc_o, mdio_oe_n_o, mdio_o});
		end
		finish_test();
	end
endmodule : testbench
`default_nettype wire
